// ===== hdl/atf_pkg.sv
// Constants and carrier types shared by the task file register decoder.
package atf_pkg;

	// ------------------------------------------------------------------
	// Register offsets inside the sixteen-slot task file window
	// ------------------------------------------------------------------
	localparam logic [3:0] OFS_DATA     = 4'h0;
	localparam logic [3:0] OFS_ERROR    = 4'h1;
	localparam logic [3:0] OFS_SCOUNT   = 4'h2;
	localparam logic [3:0] OFS_SNUM     = 4'h3;
	localparam logic [3:0] OFS_CYL_LO   = 4'h4;
	localparam logic [3:0] OFS_CYL_HI   = 4'h5;
	localparam logic [3:0] OFS_DRVHD    = 4'h6;
	localparam logic [3:0] OFS_STATUS   = 4'h7;
	localparam logic [3:0] OFS_DUP_EVEN = 4'h8;
	localparam logic [3:0] OFS_DUP_ODD  = 4'h9;
	localparam logic [3:0] OFS_DUP_ERR  = 4'hd;
	localparam logic [3:0] OFS_ALT      = 4'he;
	localparam logic [3:0] OFS_DRVADR   = 4'hf;

	// ------------------------------------------------------------------
	// Fixed I/O bases for the primary and secondary maps
	// ------------------------------------------------------------------
	localparam logic [9:0] PRI_CMD_BASE = 10'h1f0;
	localparam logic [9:0] PRI_CTL_BASE = 10'h3f6;
	localparam logic [9:0] SEC_CMD_BASE = 10'h170;
	localparam logic [9:0] SEC_CTL_BASE = 10'h376;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int         ERR_ABRT  = 2;
	localparam logic [7:0] ERR_MASK  = 8'hd5;
	localparam int         ST_BSY    = 7;
	localparam int         DH_LBA    = 6;
	localparam int         DH_DRV    = 4;
	localparam int         DC_SRST   = 2;
	localparam int         DC_NIEN   = 1;
	localparam logic [7:0] DC_RESET  = 8'h08;
	localparam logic [7:0] SC_RESET  = 8'h01;
	localparam logic [7:0] SN_RESET  = 8'h01;
	localparam logic [7:0] DH_RESET  = 8'ha0;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ------------------------------------------------------------------
	// Enumerations and carriers
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		MODE_MEM    = 5'b0_0001,
		MODE_CONTIG = 5'b0_0010,
		MODE_PRI    = 5'b0_0100,
		MODE_SEC    = 5'b0_1000,
		MODE_IDE    = 5'b1_0000
	} atf_mode_t;

	typedef enum logic [2:0] {
		PH_IDLE  = 3'b001,
		PH_READ  = 3'b010,
		PH_WRITE = 3'b100
	} atf_phase_t;

	typedef enum logic [2:0] {
		LANE_WORD = 3'b001,
		LANE_LOW  = 3'b010,
		LANE_HIGH = 3'b100
	} atf_lane_t;

	typedef struct packed {
		logic        ce1_n;
		logic        ce2_n;
		logic        reg_n;
		logic        oe_n;
		logic        we_n;
		logic        iord_n;
		logic        iowr_n;
		logic [10:0] addr;
		logic [15:0] wdata;
	} atf_pins_t;

	typedef struct packed {
		logic      hit;
		logic [3:0] ofs;
		atf_lane_t lane;
	} atf_sel_t;

	typedef struct packed {
		logic [7:0] sc;
		logic [7:0] sn;
		logic [7:0] cl;
		logic [7:0] ch;
		logic [7:0] dh;
	} atf_tf_t;

	typedef struct packed {
		logic bsy;
		logic rdy;
		logic dwf;
		logic drq;
		logic corr;
		logic err;
	} atf_core_stat_t;

	typedef struct packed {
		logic [15:0] data;
		atf_lane_t   lane;
	} atf_buf_t;

endpackage : atf_pkg

// ===== hdl/atf_task_file.sv
// Task file register decoder between the card host pins and the command core.
`timescale 1ns/1ns
module atf_task_file (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	// Configuration from the same clock domain
	input  wire atf_pkg::atf_mode_t     host_mode,
	input  wire logic                   drive_num,
	// Host pins
	input  wire logic                   ce1_n,
	input  wire logic                   ce2_n,
	input  wire logic                   reg_n,
	input  wire logic                   oe_n,
	input  wire logic                   we_n,
	input  wire logic                   iord_n,
	input  wire logic                   iowr_n,
	input  wire logic [10:0]            host_addr,
	input  wire logic [15:0]            host_din,
	output logic      [15:0]            host_dout,
	output logic                        host_doe,
	// Command core side
	output logic                        cmd_valid,
	output logic      [7:0]             cmd_code,
	output logic      [7:0]             cmd_param,
	output atf_pkg::atf_tf_t            task_file,
	output logic                        lba_mode,
	output logic                        soft_reset,
	output logic                        intrq,
	input  wire atf_pkg::atf_core_stat_t core_stat,
	input  wire logic      [7:0]        core_err_set,
	input  wire logic                   core_irq,
	input  wire logic                   core_tf_load,
	input  wire atf_pkg::atf_tf_t       core_tf,
	// Data buffer side
	input  wire logic      [15:0]       buf_rd_data,
	output logic                        buf_rd_take,
	output atf_pkg::atf_lane_t          buf_rd_lane,
	output logic                        buf_wr_push,
	output atf_pkg::atf_buf_t           buf_wr
);
	import atf_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		atf_pins_t  s1;
		atf_pins_t  s2;
		atf_phase_t ph;
		logic [15:0] dout;
		logic       doe;
		atf_tf_t    tf;
		logic [7:0] feat;
		logic [7:0] devctl;
		logic [7:0] err;
		logic [7:0] cmd;
		logic       cmd_go;
		logic       irq_pend;
		logic       bad_cmd;
		logic       rd_take;
		atf_lane_t  rlane;
		logic       wr_push;
		atf_buf_t   wbuf;
	} atf_state_t;

	atf_state_t q;
	atf_state_t n;
	atf_pins_t  pins_in;
	atf_sel_t   sel;
	logic       rd_act;
	logic       wr_act;
	logic [7:0] status_byte;
	logic [7:0] drvadr_byte;
	logic [7:0] rd_byte;
	logic [15:0] rd_word;
	logic [7:0] wr_byte;
	logic       is_data;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function automatic logic unmapped(input logic [3:0] ofs);
		unmapped = (ofs == 4'ha) || (ofs == 4'hb) || (ofs == 4'hc);
	endfunction : unmapped

	function automatic logic cmd_known(input logic [7:0] c);
		case (c)
			8'h98, 8'he5, 8'h90, 8'h50, 8'hec, 8'h97, 8'he3, 8'h95, 8'he1,
			8'h91, 8'he4, 8'h22, 8'h23, 8'hc4, 8'h20, 8'h21, 8'h40, 8'h41,
			8'hef, 8'hc6, 8'h99, 8'he6, 8'h96, 8'he2, 8'h94, 8'he0, 8'he8,
			8'h32, 8'h33, 8'hc5, 8'h30, 8'h31, 8'h03, 8'hc0, 8'h87, 8'hf5,
			8'hcd, 8'h38, 8'hff: cmd_known = 1'b1;
			default: cmd_known = (c[7:4] == 4'h1) || (c[7:4] == 4'h7);
		endcase
	endfunction : cmd_known

	function automatic atf_sel_t decode(input atf_mode_t mode, input atf_pins_t p);
		atf_sel_t   s;
		logic       lo;
		logic       hi;
		logic       cmd_hit;
		logic       ctl_hit;
		logic [3:0] a4;
		logic [9:0] cbase;
		logic [9:0] kbase;
		s = '{hit: 1'b0, ofs: OFS_DATA, lane: LANE_LOW};
		lo = ~p.ce1_n;
		hi = ~p.ce2_n;
		cbase = (mode == MODE_PRI) ? PRI_CMD_BASE : SEC_CMD_BASE;
		kbase = (mode == MODE_PRI) ? PRI_CTL_BASE : SEC_CTL_BASE;
		cmd_hit = (p.addr[9:3] == cbase[9:3]);
		ctl_hit = (p.addr[9:1] == kbase[9:1]);
		a4 = p.addr[3:0];
		case (mode)
			MODE_MEM, MODE_CONTIG: begin
				if (mode == MODE_MEM && p.addr[10]) begin
					a4 = {3'b100, p.addr[0]};
				end
				if (lo && hi) begin
					s.ofs = {a4[3:1], 1'b0};
					s.hit = (s.ofs == OFS_DATA) || (s.ofs == OFS_DUP_EVEN);
					s.lane = LANE_WORD;
				end else if (lo) begin
					s.ofs = a4;
					s.hit = !unmapped(a4);
				end else if (hi) begin
					s.ofs = {a4[3:1], 1'b1};
					s.hit = !unmapped(s.ofs);
					s.lane = LANE_HIGH;
				end
			end
			MODE_PRI, MODE_SEC: begin
				a4 = ctl_hit ? {3'b111, p.addr[0]} : {1'b0, p.addr[2:0]};
				if (lo && hi) begin
					s.hit = cmd_hit && (p.addr[2:0] == 3'h0);
					s.lane = LANE_WORD;
				end else if (lo) begin
					s.ofs = a4;
					s.hit = cmd_hit || ctl_hit;
				end else if (hi) begin
					s.ofs = {a4[3:1], 1'b1};
					s.hit = cmd_hit || ctl_hit;
					s.lane = LANE_HIGH;
				end
			end
			MODE_IDE: begin
				if (lo && !hi) begin
					s.ofs = {1'b0, p.addr[2:0]};
					s.hit = 1'b1;
					s.lane = (p.addr[2:0] == 3'h0) ? LANE_WORD : LANE_LOW;
				end else if (hi && !lo) begin
					s.ofs = {3'b111, p.addr[0]};
					s.hit = (p.addr[2:1] == 2'b11);
				end
			end
			default: s.hit = 1'b0;
		endcase
		return s;
	endfunction : decode

	// ------------------------------------------------------------------
	// Decode and read data
	// ------------------------------------------------------------------
	// Address, data and strobes share one synchroniser depth so they stay aligned.
	assign pins_in = '{ce1_n: ce1_n, ce2_n: ce2_n, reg_n: reg_n, oe_n: oe_n, we_n: we_n,
		iord_n: iord_n, iowr_n: iowr_n, addr: host_addr, wdata: host_din};

	always_comb begin
		sel = decode(host_mode, q.s2);
		if (host_mode == MODE_MEM) begin
			rd_act = !q.s2.oe_n && q.s2.reg_n;
			wr_act = !q.s2.we_n && q.s2.reg_n;
		end else begin
			rd_act = !q.s2.iord_n && !q.s2.reg_n;
			wr_act = !q.s2.iowr_n && !q.s2.reg_n;
		end
		is_data = (sel.ofs == OFS_DATA) || (sel.ofs == OFS_DUP_EVEN) ||
			(sel.ofs == OFS_DUP_ODD);
		status_byte = {core_stat.bsy | q.devctl[DC_SRST], core_stat.rdy, core_stat.dwf, 1'b1,
			core_stat.drq, core_stat.corr, 1'b0, core_stat.err | q.bad_cmd};
		drvadr_byte = {2'b11, ~q.tf.dh[3:0], ~q.tf.dh[DH_DRV], q.tf.dh[DH_DRV]};
		wr_byte = (sel.lane == LANE_HIGH) ? q.s2.wdata[15:8] : q.s2.wdata[7:0];
		case (sel.ofs)
			OFS_ERROR, OFS_DUP_ERR: rd_byte = q.err & ERR_MASK;
			OFS_SCOUNT:             rd_byte = q.tf.sc;
			OFS_SNUM:               rd_byte = q.tf.sn;
			OFS_CYL_LO:             rd_byte = q.tf.cl;
			OFS_CYL_HI:             rd_byte = q.tf.ch;
			OFS_DRVHD:              rd_byte = q.tf.dh;
			OFS_STATUS, OFS_ALT:    rd_byte = status_byte;
			OFS_DRVADR:             rd_byte = drvadr_byte;
			default:                rd_byte = buf_rd_data[7:0];
		endcase
		if (sel.lane == LANE_WORD) begin
			rd_word = buf_rd_data;
		end else if (sel.lane == LANE_HIGH) begin
			rd_word = {rd_byte, ZERO_BYTE};
		end else begin
			rd_word = {ZERO_BYTE, rd_byte};
		end
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		n = q;
		n.s1 = pins_in;
		n.s2 = q.s1;
		n.cmd_go = 1'b0;
		n.rd_take = 1'b0;
		n.wr_push = 1'b0;
		case (q.ph)
			PH_IDLE: begin
				if (rd_act && sel.hit) begin
					n.ph = PH_READ;
					n.doe = 1'b1;
					n.dout = rd_word;
					if (is_data) begin
						n.rd_take = 1'b1;
						n.rlane = sel.lane;
					end
					if (sel.ofs == OFS_STATUS) begin
						n.irq_pend = 1'b0;
					end
				end else if (wr_act && sel.hit) begin
					n.ph = PH_WRITE;
					case (sel.ofs)
						OFS_DATA, OFS_DUP_EVEN, OFS_DUP_ODD: begin
							n.wr_push = 1'b1;
							n.wbuf = '{data: q.s2.wdata, lane: sel.lane};
						end
						OFS_ERROR, OFS_DUP_ERR: n.feat = wr_byte;
						OFS_SCOUNT: n.tf.sc = wr_byte;
						OFS_SNUM:   n.tf.sn = wr_byte;
						OFS_CYL_LO: n.tf.cl = wr_byte;
						OFS_CYL_HI: n.tf.ch = wr_byte;
						OFS_DRVHD:  n.tf.dh = wr_byte;
						OFS_STATUS: begin
							if (q.tf.dh[DH_DRV] == drive_num) begin
								n.err = ZERO_BYTE;
								if (cmd_known(wr_byte)) begin
									n.cmd_go = 1'b1;
									n.cmd = wr_byte;
									n.bad_cmd = 1'b0;
								end else begin
									n.err[ERR_ABRT] = 1'b1;
									n.bad_cmd = 1'b1;
									n.irq_pend = 1'b1;
								end
							end
						end
						OFS_ALT: n.devctl = wr_byte;
						default: n.ph = PH_WRITE;
					endcase
				end
			end
			PH_READ: begin
				if (!rd_act) begin
					n.ph = PH_IDLE;
					n.doe = 1'b0;
				end
			end
			PH_WRITE: begin
				if (!wr_act) begin
					n.ph = PH_IDLE;
				end
			end
			default: begin
				n.ph = PH_IDLE;
				n.doe = 1'b0;
			end
		endcase
		if (core_tf_load) begin
			n.tf = core_tf;
		end
		n.err = n.err | (core_err_set & ERR_MASK);
		n.irq_pend = n.irq_pend | core_irq;
		// The new control value is used so the first soft reset cycle already drops the request.
		if (n.devctl[DC_SRST]) begin
			n.irq_pend = 1'b0;
			n.bad_cmd = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			q <= '{s1: '1, s2: '1, ph: PH_IDLE, dout: 16'h0000, doe: 1'b0,
				tf: '{sc: SC_RESET, sn: SN_RESET, cl: ZERO_BYTE, ch: ZERO_BYTE, dh: DH_RESET},
				feat: ZERO_BYTE, devctl: DC_RESET, err: ZERO_BYTE, cmd: ZERO_BYTE,
				cmd_go: 1'b0, irq_pend: 1'b0, bad_cmd: 1'b0, rd_take: 1'b0,
				rlane: LANE_LOW, wr_push: 1'b0, wbuf: '{data: 16'h0000, lane: LANE_LOW}};
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign host_dout   = q.dout;
	assign host_doe    = q.doe;
	assign cmd_valid   = q.cmd_go;
	assign cmd_code    = q.cmd;
	assign cmd_param   = q.feat;
	assign task_file   = q.tf;
	assign lba_mode    = q.tf.dh[DH_LBA];
	assign soft_reset  = q.devctl[DC_SRST];
	assign intrq       = q.irq_pend && !q.devctl[DC_NIEN];
	assign buf_rd_take = q.rd_take;
	assign buf_rd_lane = q.rlane;
	assign buf_wr_push = q.wr_push;
	assign buf_wr      = q.wbuf;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	status_read_clear_a: assert property (@(posedge core_clk) disable iff (reset)
		(q.ph == PH_IDLE && rd_act && sel.hit && sel.ofs == OFS_STATUS && !core_irq
		&& !core_tf_load) |=> !q.irq_pend)
		else $error("Status read left the interrupt pending.");

	alt_read_keep_a: assert property (@(posedge core_clk) disable iff (reset)
		(q.ph == PH_IDLE && rd_act && sel.hit && sel.ofs == OFS_ALT && q.irq_pend
		&& !q.devctl[DC_SRST]) |=> q.irq_pend)
		else $error("Alternate status read cleared the interrupt.");

	drive_mismatch_a: assert property (@(posedge core_clk) disable iff (reset)
		(q.ph == PH_IDLE && wr_act && sel.hit && sel.ofs == OFS_STATUS
		&& q.tf.dh[DH_DRV] != drive_num) |=> !q.cmd_go)
		else $error("Command accepted for the other drive.");

	bad_cmd_abort_a: assert property (@(posedge core_clk) disable iff (reset)
		(q.ph == PH_IDLE && wr_act && !rd_act && sel.hit && sel.ofs == OFS_STATUS
		&& q.tf.dh[DH_DRV] == drive_num && !cmd_known(wr_byte))
		|=> q.err[ERR_ABRT] && !q.cmd_go ##1 !q.cmd_go)
		else $error("Unknown command not aborted.");

	err_reserved_zero_a: assert property (@(posedge core_clk) disable iff (reset)
		(q.ph == PH_READ && sel.ofs == OFS_ERROR && sel.lane == LANE_LOW)
		|-> (q.dout[5] == 1'b0 && q.dout[3] == 1'b0 && q.dout[1] == 1'b0))
		else $error("Reserved error bit read as one.");

	unmapped_quiet_a: assert property (@(posedge core_clk) disable iff (reset)
		(q.ph == PH_IDLE && !sel.hit) |=> !q.doe && !q.wr_push && !q.cmd_go)
		else $error("Unselected access drove the bus or wrote.");

	ide_ctl_hiz_a: assert property (@(posedge core_clk) disable iff (reset)
		(host_mode == MODE_IDE && q.s2.ce1_n && (q.s2.ce2_n || q.s2.addr[2:1] != 2'b11))
		|-> !sel.hit)
		else $error("IDE control block answered outside its slots.");

	data_take_once_a: assert property (@(posedge core_clk) disable iff (reset)
		(q.ph == PH_IDLE && rd_act && sel.hit && is_data) |=> q.rd_take ##1 !q.rd_take)
		else $error("Data read did not advance the buffer exactly once.");

	srst_busy_a: assert property (@(posedge core_clk) disable iff (reset)
		q.devctl[DC_SRST] |-> status_byte[ST_BSY] && !intrq)
		else $error("Soft reset without busy or with interrupt.");

	read_drive_a: assert property (@(posedge core_clk) disable iff (reset)
		(q.ph == PH_IDLE && rd_act && sel.hit) |=> q.doe ##1 (q.doe || !$past(rd_act)))
		else $error("Selected read did not drive the bus.");

endmodule : atf_task_file

// ===== verification/atf_host_model.sv
// Host bus controller model that drives the card pins one access at a time.
`timescale 1ns/1ns
module atf_host_model (
	// Clock and configured mode
	input  wire logic               core_clk,
	input  wire atf_pkg::atf_mode_t host_mode,
	// Card pins
	output logic                    ce1_n,
	output logic                    ce2_n,
	output logic                    reg_n,
	output logic                    oe_n,
	output logic                    we_n,
	output logic                    iord_n,
	output logic                    iowr_n,
	output logic [10:0]             host_addr,
	output logic [15:0]             host_din,
	// Answer from the card
	input  wire logic [15:0]        host_dout,
	input  wire logic               host_doe
);
	import atf_pkg::*;

	initial begin
		{ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n} = 7'h7f;
		host_addr = 11'h000;
		host_din  = 16'h0000;
	end

	// --------------------------------------------------------------
	// One access
	// --------------------------------------------------------------
	// Address settles two clocks before the strobe; a slow host is a larger hold.
	// Released address and data lines show the inverse of their last value, never a stale copy.
	task automatic xfer(input logic wr, input logic [1:0] ce, input logic [10:0] a,
			input logic [15:0] wd, input int hold, output logic [15:0] rd, output logic seen);
		seen = 1'b0;
		rd   = 16'h0000;
		@(posedge core_clk);
		#2;
		{ce2_n, ce1_n} = ce;
		reg_n          = (host_mode == MODE_MEM);
		host_addr      = a;
		host_din       = wr ? wd : ~host_din;
		repeat (2) @(posedge core_clk);
		#2;
		if (host_mode == MODE_MEM) {oe_n, we_n} = {wr, ~wr};
		else {iord_n, iowr_n} = {wr, ~wr};
		repeat (hold) begin
			@(posedge core_clk);
			#1;
			if (host_doe === 1'b1) begin
				seen = 1'b1;
				rd   = host_dout;
			end
		end
		#1;
		{oe_n, we_n, iord_n, iowr_n} = 4'hf;
		repeat (4) @(posedge core_clk);
		#2;
		{ce2_n, ce1_n} = 2'h3;
		host_addr      = ~a;
		host_din       = ~host_din;
	endtask : xfer
endmodule : atf_host_model

// ===== verification/ata_task_file_register_decode_tb.sv
// Self-checking bench for the task file decoder, driven through the host model.
`timescale 1ns/1ns
module ata_task_file_register_decode_tb;
	import atf_pkg::*;

	logic           core_clk = 1'b0;
	logic           reset;
	atf_mode_t      host_mode;
	logic           drive_num;
	logic           ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n;
	logic [10:0]    host_addr;
	logic [15:0]    host_din, host_dout, buf_rd_data;
	logic           host_doe, cmd_valid, lba_mode, soft_reset, intrq;
	logic [7:0]     cmd_code, cmd_param, core_err_set;
	atf_tf_t        task_file, core_tf;
	atf_core_stat_t core_stat;
	logic           core_irq, core_tf_load, buf_rd_take, buf_wr_push;
	atf_lane_t      buf_rd_lane, last_lane;
	atf_buf_t       buf_wr, last_wr;
	int             fail_count = 0;
	int             num_checks = 0;
	int             cyc = 0;
	int             cmd_cnt = 0;
	int             take_cnt = 0;
	int             push_cnt = 0;
	logic [15:0]    d;
	logic           s;

	always #10 core_clk = ~core_clk;

	atf_task_file DUT (
		.core_clk, .reset, .host_mode, .drive_num, .ce1_n, .ce2_n, .reg_n, .oe_n, .we_n,
		.iord_n, .iowr_n, .host_addr, .host_din, .host_dout, .host_doe, .cmd_valid,
		.cmd_code, .cmd_param, .task_file, .lba_mode, .soft_reset, .intrq, .core_stat,
		.core_err_set, .core_irq, .core_tf_load, .core_tf, .buf_rd_data, .buf_rd_take,
		.buf_rd_lane, .buf_wr_push, .buf_wr
	);

	atf_host_model host (
		.core_clk, .host_mode, .ce1_n, .ce2_n, .reg_n, .oe_n, .we_n, .iord_n, .iowr_n,
		.host_addr, .host_din, .host_dout, .host_doe
	);

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic logic [10:0] adr(input logic [3:0] o);
		if (host_mode == MODE_PRI) return (o[3] ? 11'h3f0 : 11'h1f0) | {8'h00, o[2:0]};
		if (host_mode == MODE_SEC) return (o[3] ? 11'h370 : 11'h170) | {8'h00, o[2:0]};
		if (host_mode == MODE_IDE) return {8'h55, o[2:0]};
		return {7'h2a, o};
	endfunction : adr

	function automatic logic [1:0] ce_of(input logic [3:0] o);
		return (host_mode == MODE_IDE && o[3]) ? 2'b01 : 2'b10;
	endfunction : ce_of

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic rreg(input logic [3:0] o);
		host.xfer(1'b0, ce_of(o), adr(o), 16'h0000, 5, d, s);
		d = {8'h00, d[7:0]};
	endtask : rreg

	task automatic wreg(input logic [3:0] o, input logic [7:0] val);
		host.xfer(1'b1, ce_of(o), adr(o), {8'h00, val}, 5, d, s);
	endtask : wreg

	task automatic tick;
		@(posedge core_clk);
		#2;
	endtask : tick

	task automatic end_sim;
		if (fail_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_modes;
		atf_mode_t m [5] = '{MODE_MEM, MODE_CONTIG, MODE_PRI, MODE_SEC, MODE_IDE};
		logic [7:0] x;
		rreg(OFS_SCOUNT);
		check(d, 16'h0001);
		foreach (m[i]) begin
			host_mode = m[i];
			x = 8'h30 + 8'(i);
			wreg(OFS_SCOUNT, x);
			rreg(OFS_SCOUNT);
			check(d, 16'(x));
			rreg(OFS_ALT);
			check(16'(s), 16'h0001);
		end
		host_mode = MODE_MEM;
	endtask : t_modes

	task automatic t_lanes;
		wreg(OFS_SNUM, 8'h5c);
		host.xfer(1'b0, 2'b01, {7'h2a, 4'h2}, 16'h0000, 9, d, s);
		check(d & 16'hff00, 16'h5c00);
		host.xfer(1'b1, 2'b01, {7'h2a, 4'h4}, 16'h7700, 5, d, s);
		check(16'(task_file.ch), 16'h0077);
	endtask : t_lanes

	task automatic t_status;
		core_stat = '{bsy:1'b0, rdy:1'b1, dwf:1'b1, drq:1'b0, corr:1'b1, err:1'b0};
		tick;
		core_irq = 1'b1;
		tick;
		core_irq = 1'b0;
		rreg(OFS_ALT);
		check(d, 16'h0074);
		check(16'(intrq), 16'h0001);
		rreg(OFS_STATUS);
		check(d, 16'h0074);
		check(16'(intrq), 16'h0000);
		tick;
		core_irq = 1'b1;
		tick;
		core_irq = 1'b0;
		wreg(OFS_ALT, 8'h0a);
		check(16'(intrq), 16'h0000);
		wreg(OFS_ALT, 8'h0c);
		rreg(OFS_STATUS);
		check(d, 16'h00f4);
		check(16'(soft_reset), 16'h0001);
		check(16'(intrq), 16'h0000);
		wreg(OFS_ALT, 8'h08);
		check(16'(soft_reset), 16'h0000);
	endtask : t_status

	task automatic t_cmd;
		int n;
		wreg(OFS_DRVHD, 8'he0);
		check(16'(lba_mode), 16'h0001);
		rreg(OFS_DRVADR);
		check(d, 16'h00fe);
		wreg(OFS_DRVADR, 8'h00);
		rreg(OFS_DRVHD);
		check(d, 16'h00e0);
		wreg(OFS_ERROR, 8'h5a);
		check(16'(cmd_param), 16'h005a);
		rreg(OFS_ERROR);
		check(d, 16'h0000);
		n = cmd_cnt;
		wreg(OFS_STATUS, 8'h20);
		check(16'(cmd_cnt - n), 16'h0001);
		check(16'(cmd_code), 16'h0020);
		wreg(OFS_DRVHD, 8'hf0);
		wreg(OFS_STATUS, 8'h30);
		wreg(OFS_DRVHD, 8'he0);
		wreg(OFS_STATUS, 8'h00);
		check(16'(cmd_cnt - n), 16'h0001);
		rreg(OFS_DUP_ERR);
		check(d, 16'h0004);
		rreg(OFS_STATUS);
		check(16'(d[0]), 16'h0001);
		tick;
		core_err_set = 8'hff;
		tick;
		core_err_set = 8'h00;
		rreg(OFS_ERROR);
		check(d, 16'h00d5);
	endtask : t_cmd

	task automatic t_tf;
		core_tf = '{sc:8'h03, sn:8'h44, cl:8'h55, ch:8'h66, dh:8'ha1};
		tick;
		core_tf_load = 1'b1;
		tick;
		core_tf_load = 1'b0;
		for (int k = 0; k < 4; k++) begin
			rreg(OFS_SCOUNT + 4'(k));
			check(d, 16'(core_tf[39 - 8 * k -: 8]));
		end
		check(16'(lba_mode), 16'h0000);
	endtask : t_tf

	task automatic t_data;
		int n;
		int p;
		n = take_cnt;
		p = push_cnt;
		host.xfer(1'b0, 2'b00, 11'h4a7, 16'h0000, 8, d, s);
		check(d, 16'hbeef);
		check(16'(last_lane), 16'(LANE_WORD));
		host.xfer(1'b0, 2'b10, 11'h5c3, 16'h0000, 5, d, s);
		check(16'(take_cnt - n), 16'h0002);
		host.xfer(1'b1, 2'b01, 11'h433, 16'h5a00, 5, d, s);
		check(16'(push_cnt - p), 16'h0001);
		check({last_wr.data[15:8], 5'h00, last_wr.lane}, 16'h5a04);
		host.xfer(1'b1, 2'b00, {7'h2a, OFS_DUP_EVEN}, 16'h1234, 5, d, s);
		check(last_wr.data, 16'h1234);
		host_mode = MODE_CONTIG;
		host.xfer(1'b0, 2'b00, {7'h15, OFS_DATA}, 16'h0000, 5, d, s);
		check(16'(take_cnt - n), 16'h0003);
		host_mode = MODE_MEM;
	endtask : t_data

	task automatic t_refuse;
		atf_mode_t   m [5] = '{MODE_MEM, MODE_PRI, MODE_SEC, MODE_IDE, MODE_IDE};
		logic [1:0]  c [5] = '{2'b10, 2'b10, 2'b10, 2'b00, 2'b01};
		logic [10:0] a [5] = '{11'h2aa, 11'h1f8, 11'h1f2, 11'h002, 11'h005};
		foreach (m[i]) begin
			host_mode = m[i];
			host.xfer(1'b0, c[i], a[i], 16'h0000, 5, d, s);
			check(16'(s), 16'h0000);
		end
		host.xfer(1'b1, 2'b01, 11'h002, 16'h9999, 5, d, s);
		check(16'(task_file.sc), 16'h0003);
	endtask : t_refuse

	// --------------------------------------------------------------
	// Monitors, timeout and main sequence
	// --------------------------------------------------------------
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cmd_valid === 1'b1) cmd_cnt <= cmd_cnt + 1;
		if (buf_rd_take === 1'b1) take_cnt <= take_cnt + 1;
		if (buf_rd_take === 1'b1) last_lane <= buf_rd_lane;
		if (buf_wr_push === 1'b1) push_cnt <= push_cnt + 1;
		if (buf_wr_push === 1'b1) last_wr <= buf_wr;
		if (cyc == 3000) begin
			fail_count++;
			end_sim;
		end
	end

	initial begin
		reset        = 1'b1;
		host_mode    = MODE_MEM;
		drive_num    = 1'b0;
		core_stat    = '0;
		core_err_set = 8'h00;
		core_irq     = 1'b0;
		core_tf_load = 1'b0;
		core_tf      = '0;
		buf_rd_data  = 16'hbeef;
		repeat (6) @(posedge core_clk);
		#2;
		reset = 1'b0;
		t_modes;
		t_lanes;
		t_status;
		t_cmd;
		t_tf;
		t_data;
		t_refuse;
		end_sim;
	end
endmodule : ata_task_file_register_decode_tb
